// >>> logic/seconds_alarm_pkg.sv
/*
  Shared constants for the seconds counter with match alarm: register byte
  offsets, field positions, reset values and the AXI4-Lite answer codes.
  Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
*/
package seconds_alarm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  localparam logic [ADDR_W-1:0] OFS_LIVE_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRELOAD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h14;

  localparam int MATCH_IRQ_BIT = 0;
  localparam int MATCH_IRQ_ENABLE_BIT = 0;

  localparam logic [DATA_W-1:0] RST_COUNT = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_PRELOAD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_COMPARE = 32'h0000_0000;
  localparam logic RST_MATCH_IRQ_ENABLE = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : seconds_alarm_pkg

// >>> logic/seconds_alarm.sv
/*
  Seconds counter with a programmable match alarm behind an AXI4-Lite slave.
  Assumes second_tick_clk and millisecond_clk are free-running square waves from
  outside the aclk domain; both are synchronised and edge-detected here, so the
  whole block runs on aclk alone.
*/
// The implementer's own choice: register access over AXI4-Lite.
// Notes on behaviour
// - 32-bit counter increments on each rising edge of the one-second tick.
// - A preload write is copied into the counter at the next tick.
// - Counter wraps from all ones to zero silently and keeps counting.
// - Match from an increment raises the interrupt at the next millisecond edge.
// - Status bit 0 shows the interrupt; bits 31 to 1 read zero.
// - Any write to the clear register drops the interrupt and status bit.
// - Status and clear share one address; reads status, writes clear.
// - With the enable bit zero, a match raises no interrupt.
// - After reset the match interrupt is disabled.
// - Reading the live count returns a snapshot without disturbing counting.
// - Reading preload returns the last written value, not the count.
// - Compare is a 32-bit read-write store returning the last write.
// - Control bits 31 to 1 are written as zero and read zero.
// - The one-second tick keeps counting in reduced-power modes.
`timescale 1ns/1ns
module seconds_alarm (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic second_tick_clk,
  input wire logic millisecond_clk,
  input wire logic [seconds_alarm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [seconds_alarm_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [seconds_alarm_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [seconds_alarm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [seconds_alarm_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic match_irq
);
  import seconds_alarm_pkg::*;

  typedef struct packed {
    logic sec_s1;
    logic sec_s2;
    logic sec_s3;
    logic ms_s1;
    logic ms_s2;
    logic ms_s3;
    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] preload;
    logic [DATA_W-1:0] compare;
    logic match_irq_enable;
    logic load_pending;
    logic match_pending;
    logic irq_state;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] rd_addr;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic sec_rise;
  logic ms_rise;
  logic wr_fire;
  logic clear_fire;
  logic preload_fire;
  logic [DATA_W-1:0] count_inc;

  // Merges a write into a stored word one byte lane at a time.
  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_val,
                                                    input logic [DATA_W-1:0] new_val,
                                                    input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_lanes

  // Only the second and third stages feed the edge detectors; the first stage
  // may be metastable and is read by the second stage alone.
  assign sec_rise = st_reg.sec_s2 & ~st_reg.sec_s3;
  assign ms_rise = st_reg.ms_s2 & ~st_reg.ms_s3;
  assign count_inc = st_reg.count + 32'h0000_0001;
  assign wr_fire = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
  assign clear_fire = wr_fire && (st_reg.aw_addr == OFS_IRQ_CLEAR);
  assign preload_fire = wr_fire && (st_reg.aw_addr == OFS_PRELOAD);

  assign s_axi_awready = ~st_reg.aw_held & ~st_reg.bvalid;
  assign s_axi_wready = ~st_reg.w_held & ~st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = ~st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign match_irq = st_reg.irq_state & st_reg.match_irq_enable;

  always_comb begin
    st_next = st_reg;

    // The tick is only sampled here, never gated, so counting goes on in
    // every power mode as long as the tick pin toggles.
    st_next.sec_s1 = second_tick_clk;
    st_next.sec_s2 = st_reg.sec_s1;
    st_next.sec_s3 = st_reg.sec_s2;
    st_next.ms_s1 = millisecond_clk;
    st_next.ms_s2 = st_reg.ms_s1;
    st_next.ms_s3 = st_reg.ms_s2;

    // The launch retires the pending match first, so a new match in the same cycle survives.
    if (ms_rise && st_reg.match_pending) begin
      st_next.match_pending = 1'b0;
    end

    if (sec_rise) begin
      if (st_reg.load_pending) begin
        st_next.count = st_reg.preload;
        st_next.load_pending = 1'b0;
      end else begin
        st_next.count = count_inc;
        if (count_inc == st_reg.compare && st_reg.match_irq_enable) begin
          st_next.match_pending = 1'b1;
        end
      end
    end

    // A clear and a new launch in the same cycle: the launch wins.
    if (ms_rise && st_reg.match_pending) begin
      st_next.irq_state = 1'b1;
    end else if (clear_fire) begin
      st_next.irq_state = 1'b0;
    end

    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    if (wr_fire) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      if (st_reg.aw_addr == OFS_LIVE_COUNT) begin
        st_next.bresp = RESP_OKAY;
      end else if (st_reg.aw_addr == OFS_PRELOAD) begin
        st_next.preload = merge_lanes(st_reg.preload, st_reg.w_data, st_reg.w_strb);
        // A write landing on the tick itself stays pending for the next tick.
        st_next.load_pending = 1'b1;
      end else if (st_reg.aw_addr == OFS_COMPARE) begin
        st_next.compare = merge_lanes(st_reg.compare, st_reg.w_data, st_reg.w_strb);
      end else if (st_reg.aw_addr == OFS_IRQ_CLEAR) begin
        st_next.bresp = RESP_OKAY;
      end else if (st_reg.aw_addr == OFS_CONTROL) begin
        if (st_reg.w_strb[0]) begin
          st_next.match_irq_enable = st_reg.w_data[MATCH_IRQ_ENABLE_BIT];
        end
      end else begin
        st_next.bresp = RESP_SLVERR;
      end
    end else if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rd_addr = s_axi_araddr;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      if (s_axi_araddr == OFS_LIVE_COUNT) begin
        st_next.rdata = st_reg.count;
      end else if (s_axi_araddr == OFS_PRELOAD) begin
        st_next.rdata = st_reg.preload;
      end else if (s_axi_araddr == OFS_COMPARE) begin
        st_next.rdata = st_reg.compare;
      end else if (s_axi_araddr == OFS_IRQ_STATE) begin
        st_next.rdata[MATCH_IRQ_BIT] = st_reg.irq_state;
      end else if (s_axi_araddr == OFS_CONTROL) begin
        st_next.rdata[MATCH_IRQ_ENABLE_BIT] = st_reg.match_irq_enable;
      end else begin
        st_next.rresp = RESP_SLVERR;
      end
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.count <= RST_COUNT;
      st_reg.preload <= RST_PRELOAD;
      st_reg.compare <= RST_COMPARE;
      st_reg.match_irq_enable <= RST_MATCH_IRQ_ENABLE;
    end else begin
      st_reg <= st_next;
    end
  end

  sequence s_match_armed;
    sec_rise && !st_reg.load_pending && st_reg.match_irq_enable && (count_inc == st_reg.compare);
  endsequence

  sequence s_launch;
    ms_rise && st_reg.match_pending;
  endsequence

  property p_count_inc;
    @(posedge aclk) disable iff (!aresetn)
      sec_rise && !st_reg.load_pending |=> st_reg.count == $past(st_reg.count) + 32'h0000_0001;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("count did not step by one on a tick");

  property p_preload;
    @(posedge aclk) disable iff (!aresetn)
      sec_rise && st_reg.load_pending |=> st_reg.count == $past(st_reg.preload) &&
        (!st_reg.load_pending || $past(preload_fire));
  endproperty
  a_preload: assert property (p_preload) else $error("preload not copied at tick");

  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
      sec_rise && !st_reg.load_pending && st_reg.count == 32'hffff_ffff |=> st_reg.count == 32'h0000_0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap to zero");

  property p_match_launch;
    @(posedge aclk) disable iff (!aresetn)
      s_match_armed |=> st_reg.match_pending;
  endproperty
  a_match_launch: assert property (p_match_launch) else $error("matching tick did not arm a launch");

  property p_launch;
    @(posedge aclk) disable iff (!aresetn)
      s_launch |=> st_reg.irq_state;
  endproperty
  a_launch: assert property (p_launch) else $error("interrupt not raised at next millisecond edge");

  property p_status_read;
    @(posedge aclk) disable iff (!aresetn)
      st_reg.rvalid && st_reg.rd_addr == OFS_IRQ_STATE |-> st_reg.rdata[DATA_W-1:1] == 31'h0000_0000;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status upper bits not zero");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
      clear_fire && !(ms_rise && st_reg.match_pending) |=> !st_reg.irq_state && !match_irq;
  endproperty
  a_clear: assert property (p_clear) else $error("clear write left interrupt set");

  property p_no_match_disabled;
    @(posedge aclk) disable iff (!aresetn)
      sec_rise && !st_reg.match_irq_enable && !st_reg.match_pending |=> !st_reg.match_pending;
  endproperty
  a_no_match_disabled: assert property (p_no_match_disabled) else $error("match armed while disabled");

  property p_reset_disabled;
    @(posedge aclk) !$past(aresetn) |-> !st_reg.match_irq_enable && !match_irq;
  endproperty
  a_reset_disabled: assert property (p_reset_disabled) else $error("interrupt enabled after reset");

  property p_preload_read;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && !st_reg.rvalid && s_axi_araddr == OFS_PRELOAD |=> st_reg.rdata == $past(st_reg.preload);
  endproperty
  a_preload_read: assert property (p_preload_read) else $error("preload read returned wrong value");

  property p_control_read;
    @(posedge aclk) disable iff (!aresetn)
      st_reg.rvalid && st_reg.rd_addr == OFS_CONTROL |-> st_reg.rdata[DATA_W-1:1] == 31'h0000_0000;
  endproperty
  a_control_read: assert property (p_control_read) else $error("control upper bits not zero");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
      st_reg.irq_state && !clear_fire |=> st_reg.irq_state;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped without clear");

  property p_load_arm;
    @(posedge aclk) disable iff (!aresetn)
      preload_fire |=> st_reg.load_pending;
  endproperty
  a_load_arm: assert property (p_load_arm) else $error("preload write did not arm a load");

  property p_count_read;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && !st_reg.rvalid && s_axi_araddr == OFS_LIVE_COUNT |=> st_reg.rdata == $past(st_reg.count);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read returned wrong value");

  property p_count_steady;
    @(posedge aclk) disable iff (!aresetn)
      !sec_rise |=> st_reg.count == $past(st_reg.count);
  endproperty
  a_count_steady: assert property (p_count_steady) else $error("count moved without a tick");

  property p_compare_read;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && !st_reg.rvalid && s_axi_araddr == OFS_COMPARE |=> st_reg.rdata == $past(st_reg.compare);
  endproperty
  a_compare_read: assert property (p_compare_read) else $error("compare read returned wrong value");

  property p_status_value;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && !st_reg.rvalid && s_axi_araddr == OFS_IRQ_STATE |=> st_reg.rdata[0] == $past(st_reg.irq_state);
  endproperty
  a_status_value: assert property (p_status_value) else $error("status bit does not show interrupt");

  property p_clear_okay;
    @(posedge aclk) disable iff (!aresetn)
      clear_fire |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY;
  endproperty
  a_clear_okay: assert property (p_clear_okay) else $error("clear write not answered okay");

  property p_enable_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire && st_reg.aw_addr == OFS_CONTROL && st_reg.w_strb[0] |=>
        st_reg.match_irq_enable == $past(st_reg.w_data[MATCH_IRQ_ENABLE_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not taken from write");

endmodule : seconds_alarm

// >>> testbench/time_base_model.sv
/*
  Pin model of the two slow clocks, scaled down so a run stays short.
  Assumes aclk is the bench clock and tick_go asks for one second tick.
*/
`timescale 1ns/1ns
module time_base_model (
  input wire logic aclk,
  input wire logic tick_go,
  output logic second_tick_clk,
  output logic millisecond_clk
);
  logic [4:0] ms_cnt = 5'h00;
  logic [3:0] tick_cnt = 4'h0;
  // The tick stays high for 8 cycles, so the pin synchroniser cannot miss it.
  always @(posedge aclk) begin
    ms_cnt <= ms_cnt + 5'h01;
    if (tick_go) begin
      tick_cnt <= 4'h8;
    end else if (tick_cnt != 4'h0) begin
      tick_cnt <= tick_cnt - 4'h1;
    end
  end
  assign millisecond_clk = ms_cnt[4];
  assign second_tick_clk = tick_cnt != 4'h0;
endmodule : time_base_model

// >>> testbench/test_seconds_counter_match_alarm.sv
/*
  Self-checking bench for the seconds counter with match alarm.
  Assumes the design's AXI4-Lite slave and the scaled slow-clock model.
*/
`timescale 1ns/1ns
module test_seconds_counter_match_alarm;
  import seconds_alarm_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] q;
    logic [1:0] br;
    logic [1:0] rr;
  } row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic tick_go = 1'b0;
  logic sec_clk, ms_clk;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata, q;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, match_irq;
  logic [1:0] bresp, rresp, resp;
  int error_cnt = 0;
  int tests_run = 0;
  row_t rows [7];

  always #10 aclk = ~aclk;

  // Both ready inputs stay high: the master may always take an answer.
  seconds_alarm u_dut (.aclk(aclk), .aresetn(aresetn), .second_tick_clk(sec_clk), .millisecond_clk(ms_clk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .match_irq(match_irq));
  time_base_model u_clk (.aclk(aclk), .tick_go(tick_go), .second_tick_clk(sec_clk), .millisecond_clk(ms_clk));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, where outputs have settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    if (i == 40) begin
      error_cnt++;
      summarize();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ta, tb;
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tb = rvalid;
      q = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tb) break;
    end
    if (i == 40) begin
      error_cnt++;
      summarize();
    end
  endtask : rd

  task automatic tick;
    tick_go <= 1'b1;
    @(posedge aclk);
    tick_go <= 1'b0;
    repeat (14) @(posedge aclk);
  endtask : tick

  task automatic irq_is(input logic exp);
    int i;
    for (i = 0; i < 40 && match_irq !== exp; i++) @(negedge aclk);
    @(negedge aclk);
    chk({31'h0, match_irq}, {31'h0, exp});
    @(posedge aclk);
  endtask : irq_is

  initial begin
    rows = '{'{OFS_PRELOAD, 32'h1234_5678, 32'h1234_5678, RESP_OKAY, RESP_OKAY},
      '{OFS_COMPARE, 32'ha5a5_0f0f, 32'ha5a5_0f0f, RESP_OKAY, RESP_OKAY},
      '{OFS_CONTROL, 32'h0000_0001, 32'h0000_0001, RESP_OKAY, RESP_OKAY},
      '{OFS_CONTROL, 32'h0000_0000, 32'h0000_0000, RESP_OKAY, RESP_OKAY},
      '{OFS_LIVE_COUNT, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY, RESP_OKAY},
      '{OFS_IRQ_CLEAR, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY, RESP_OKAY},
      '{8'h18, 32'hffff_ffff, 32'h0000_0000, RESP_SLVERR, RESP_SLVERR}};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    chk({29'h0, awready, wready, arready}, 32'h0000_0007);
    @(posedge aclk);
    rd(OFS_CONTROL);
    chk(q, 32'h0);
    irq_is(1'b0);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      chk({30'h0, resp}, {30'h0, rows[k].br});
      rd(rows[k].a);
      chk(q, rows[k].q);
      chk({30'h0, resp}, {30'h0, rows[k].rr});
    end
    wr(OFS_PRELOAD, 32'hffff_fffe);
    wr(OFS_COMPARE, 32'h0);
    wr(OFS_CONTROL, 32'h1);
    tick();
    rd(OFS_LIVE_COUNT);
    chk(q, 32'hffff_fffe);
    tick();
    rd(OFS_LIVE_COUNT);
    chk(q, 32'hffff_ffff);
    tick();
    irq_is(1'b1);
    rd(OFS_LIVE_COUNT);
    chk(q, 32'h0);
    rd(OFS_IRQ_STATE);
    chk(q, 32'h1);
    tick();
    irq_is(1'b1);
    rd(OFS_LIVE_COUNT);
    chk(q, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'hdead_beef);
    irq_is(1'b0);
    rd(OFS_IRQ_STATE);
    chk(q, 32'h0);
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_PRELOAD, 32'h5);
    tick();
    wr(OFS_COMPARE, 32'h6);
    tick();
    repeat (40) @(posedge aclk);
    irq_is(1'b0);
    rd(OFS_IRQ_STATE);
    chk(q, 32'h0);
    rd(OFS_LIVE_COUNT);
    chk(q, 32'h6);
    wr(OFS_CONTROL, 32'h1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    chk({29'h0, awready, wready, arready}, 32'h0000_0007);
    chk({31'h0, match_irq}, 32'h0);
    @(posedge aclk);
    rd(OFS_CONTROL);
    chk(q, 32'h0);
    summarize();
  end
endmodule : test_seconds_counter_match_alarm
